// ===== pkg/etp_pkg.sv
// Package: constants and types for enclave trace and perfmon gating
package etp_pkg;
  localparam int ADDR_W         = 64;
  localparam int SRC_PRED_BIT   = 63;  // Predicted mark in record source
  localparam int FILT_FAR_BIT   = 8;   // Far-branch filter in record filter
  localparam int GSTAT_AI_BIT   = 60;  // Anti-interference flag position
  localparam int FILT_W         = 16;
  localparam int NUM_GP_CTR     = 4;
  localparam int NUM_FIX_CTR    = 3;
  localparam int CYC_FIX_LO     = 1;   // Cycle-counting fixed counters
  localparam int CYC_FIX_HI     = 2;

  // Enclave event kinds from retirement
  typedef enum logic [2:0] {
    ETP_EV_NONE   = 3'h0,
    ETP_EV_ENTER  = 3'h1,
    ETP_EV_RESUME = 3'h2,
    ETP_EV_EXIT   = 3'h3,
    ETP_EV_AEX    = 3'h4,
    ETP_EV_SLEAF  = 3'h5,  // Supervisor leaf, key fetch or attest report
    ETP_EV_BRANCH = 3'h6
  } etp_ev_t;

  // Enclave residency state, one-hot
  typedef enum logic [2:0] {
    ETP_ST_OUT    = 3'h1,
    ETP_ST_OPTIN  = 3'h2,
    ETP_ST_OPTOUT = 3'h4
  } etp_st_t;
endpackage : etp_pkg

// ===== pkg/etp_rec_if.sv
// Interface: branch record push path between main logic and recorder
`timescale 1ns/10ps
interface etp_rec_if;
  import etp_pkg::*;
  logic              push;
  logic [ADDR_W-1:0] src;
  logic [ADDR_W-1:0] dst;
  logic              far;
  modport producer (output push, output src, output dst, output far);
  modport consumer (input push, input src, input dst, input far);
endinterface : etp_rec_if

// ===== verilog/etp_rec_out.sv
// Branch record output stage with far-branch filtering
`timescale 1ns/10ps
module etp_rec_out
  import etp_pkg::*;
(
  input  wire logic              mclk,      // Core clock
  input  wire logic              reset,     // Sync reset
  etp_rec_if.consumer            rec,       // Record requests
  input  wire logic [FILT_W-1:0] filt,      // Branch record filter
  output logic                   rec_valid, // Record pushed
  output logic [ADDR_W-1:0]      rec_src,   // Record source
  output logic [ADDR_W-1:0]      rec_dst,   // Record target
  output logic                   rec_ntx    // Non-transactional mark
);
  import etp_pkg::*;
  logic              next_valid;
  logic [ADDR_W-1:0] next_src;
  logic [ADDR_W-1:0] next_dst;
  logic              next_ntx;

  always_comb begin
    // Set filter bit suppresses far-branch records
    next_valid = rec.push && !(rec.far && filt[FILT_FAR_BIT]);
    next_src   = rec_src;
    next_dst   = rec_dst;
    next_ntx   = rec_ntx;
    if (next_valid) begin
      next_src = rec.src;
      next_dst = rec.dst;
      if (rec.far) begin
        next_src[SRC_PRED_BIT] = 1'b1;
      end
      next_ntx = rec.far;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      rec_valid <= 1'b0;
      rec_src   <= '0;
      rec_dst   <= '0;
      rec_ntx   <= 1'b0;
    end else begin
      rec_valid <= next_valid;
      rec_src   <= next_src;
      rec_dst   <= next_dst;
      rec_ntx   <= next_ntx;
    end
  end

  pred_mark_a: assert property (@(posedge mclk) disable iff (reset)
    rec.push && rec.far && !filt[FILT_FAR_BIT] |=> rec_valid && rec_src[SRC_PRED_BIT])
    else $error("enclave record not marked predicted");
  far_filter_a: assert property (@(posedge mclk) disable iff (reset)
    rec.push && rec.far && filt[FILT_FAR_BIT] |=> !rec_valid)
    else $error("filtered far record pushed");
endmodule : etp_rec_out

// ===== verilog/etp_gate.sv
// Enclave trace and performance monitoring gating, one logical processor
`timescale 1ns/10ps
module etp_gate
  import etp_pkg::*;
(
  input  wire logic                   mclk,            // Core clock, 200 MHz
  input  wire logic                   reset,           // Sync reset, active high
  input  wire etp_pkg::etp_ev_t       ev_kind,         // Retired event kind
  input  wire logic                   ev_optin,        // Entry is opt-in
  input  wire logic [ADDR_W-1:0]      ev_ip,           // Instruction address
  input  wire logic [ADDR_W-1:0]      ev_dst,          // Destination address
  input  wire logic [ADDR_W-1:0]      ssa_ip,          // Saved address in save area
  input  wire logic [ADDR_W-1:0]      landing_addr,    // Async exit landing address
  input  wire logic                   branch_single_step, // Single-step on branches
  input  wire logic                   rec_enable,      // Branch recording enabled
  input  wire logic [FILT_W-1:0]      rec_filter,      // Branch record filter
  input  wire logic                   pev_pending,     // Precise event pending
  input  wire logic                   eee_done,        // Exiting event delivered
  input  wire logic                   ev_cause_rec,    // Causing event pushes record
  input  wire logic [ADDR_W-1:0]      cause_dst,       // Causing event target
  input  wire logic [NUM_GP_CTR-1:0]  sib_both_cfg,    // Sibling both-thread configs
  input  wire logic                   sib_optout,      // Sibling in opt-out enclave
  output logic                        ss_exc,          // Single-step exception pulse
  output logic                        rec_valid,       // Record pushed
  output logic [ADDR_W-1:0]           rec_src,         // Record source
  output logic [ADDR_W-1:0]           rec_dst,         // Record target
  output logic                        rec_ntx,         // Non-transactional record
  output logic                        anti_interference_flag, // Status bit 60 value
  output logic [63:0]                 perf_global_state, // Status word
  output logic [NUM_GP_CTR-1:0]       gp_ctr_en,       // General counters enable
  output logic [NUM_FIX_CTR-1:0]      fix_ctr_en,      // Fixed counters enable
  output logic                        pev_en,          // Precise records allowed
  output logic [NUM_GP_CTR-1:0]       sib_both_eff,    // Sibling effective both-thread
  output logic                        pev_valid,       // Precise record emitted
  output logic [ADDR_W-1:0]           eventing_address // Precise record address
);
  import etp_pkg::*;

  // ----------------------------------------------------------------
  // Residency state
  // ----------------------------------------------------------------
  etp_st_t           st;
  etp_st_t           next_st;
  logic [ADDR_W-1:0] entry_ip;
  logic [ADDR_W-1:0] next_entry_ip;
  logic              rec_at_entry;
  logic              next_rec_at_entry;

  logic is_entry;
  logic is_leave;
  assign is_entry = (ev_kind == ETP_EV_ENTER) || (ev_kind == ETP_EV_RESUME);
  assign is_leave = (ev_kind == ETP_EV_EXIT) || (ev_kind == ETP_EV_AEX);

  always_comb begin
    next_st           = st;
    next_entry_ip     = entry_ip;
    next_rec_at_entry = rec_at_entry;
    case (st)
      ETP_ST_OUT: begin
        if (is_entry) begin
          next_st           = ev_optin ? ETP_ST_OPTIN : ETP_ST_OPTOUT;
          next_entry_ip     = ev_ip;
          next_rec_at_entry = rec_enable;
        end
      end
      ETP_ST_OPTIN, ETP_ST_OPTOUT: begin
        if (is_leave) begin
          next_st = ETP_ST_OUT;
        end
      end
      default: next_st = ETP_ST_OUT;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      st           <= ETP_ST_OUT;
      entry_ip     <= '0;
      rec_at_entry <= 1'b0;
    end else begin
      st           <= next_st;
      entry_ip     <= next_entry_ip;
      rec_at_entry <= next_rec_at_entry;
    end
  end

  // ----------------------------------------------------------------
  // Branch record generation
  // ----------------------------------------------------------------
  // Opt-out async exit with a causing record needs a second push cycle
  etp_rec_if rec_bus ();
  logic              two_pend;
  logic              next_two_pend;
  logic [ADDR_W-1:0] two_dst;
  logic [ADDR_W-1:0] next_two_dst;
  logic              r_push;
  logic [ADDR_W-1:0] r_src;
  logic [ADDR_W-1:0] r_dst;
  logic              r_far;

  always_comb begin
    r_push        = 1'b0;
    r_src         = '0;
    r_dst         = '0;
    r_far         = 1'b0;
    next_two_pend = 1'b0;
    next_two_dst  = two_dst;
    if (two_pend) begin
      r_push = 1'b1;
      r_src  = landing_addr;
      r_dst  = two_dst;
    end else if (st == ETP_ST_OUT) begin
      if (is_entry && ev_optin && rec_enable) begin
        r_push = 1'b1;
        r_src  = ev_ip;
        r_dst  = ev_dst;
        r_far  = 1'b1;
      end else if (ev_kind == ETP_EV_BRANCH && rec_enable) begin
        r_push = 1'b1;
        r_src  = ev_ip;
        r_dst  = ev_dst;
      end
    end else if (st == ETP_ST_OPTIN && rec_enable) begin
      if (ev_kind == ETP_EV_EXIT) begin
        r_push = 1'b1;
        r_src  = ev_ip;
        r_dst  = ev_dst;
        r_far  = 1'b1;
      end else if (ev_kind == ETP_EV_AEX) begin
        r_push = 1'b1;
        r_src  = ssa_ip;
        r_dst  = landing_addr;
        r_far  = 1'b1;
      end else if (ev_kind == ETP_EV_BRANCH) begin
        r_push = 1'b1;
        r_src  = ev_ip;
        r_dst  = ev_dst;
      end
    end else if (st == ETP_ST_OPTOUT && rec_at_entry) begin
      // Branches inside are never recorded here
      if (ev_kind == ETP_EV_EXIT) begin
        r_push = 1'b1;
        r_src  = entry_ip;
        r_dst  = ev_dst;
        r_far  = 1'b1;
      end else if (ev_kind == ETP_EV_AEX) begin
        r_push        = 1'b1;
        r_src         = entry_ip;
        r_dst         = landing_addr;
        r_far         = 1'b1;
        next_two_pend = ev_cause_rec;
        next_two_dst  = cause_dst;
      end
    end
  end

  assign rec_bus.push = r_push;
  assign rec_bus.src  = r_src;
  assign rec_bus.dst  = r_dst;
  assign rec_bus.far  = r_far;

  always_ff @(posedge mclk) begin
    if (reset) begin
      two_pend <= 1'b0;
      two_dst  <= '0;
    end else begin
      two_pend <= next_two_pend;
      two_dst  <= next_two_dst;
    end
  end

  etp_rec_out u_rec (
    .mclk      (mclk),
    .reset     (reset),
    .rec       (rec_bus.consumer),
    .filt      (rec_filter),
    .rec_valid (rec_valid),
    .rec_src   (rec_src),
    .rec_dst   (rec_dst),
    .rec_ntx   (rec_ntx)
  );

  // ----------------------------------------------------------------
  // Single-step, counters, precise records
  // ----------------------------------------------------------------
  logic                   next_ss;
  logic                   optout_next;
  logic [NUM_FIX_CTR-1:0] next_fix;
  logic                   next_pev_valid;
  logic [ADDR_W-1:0]      next_ev_addr;
  logic                   pev2_arm;
  logic                   next_pev2_arm;

  always_comb begin
    next_ss = branch_single_step &&
              (((ev_kind == ETP_EV_ENTER) && ev_optin && st == ETP_ST_OUT) ||
               ((ev_kind == ETP_EV_EXIT) && st != ETP_ST_OUT));
    optout_next = (next_st == ETP_ST_OPTOUT);
    for (int i = 0; i < NUM_FIX_CTR; i++) begin
      next_fix[i] = !optout_next || (i >= CYC_FIX_LO && i <= CYC_FIX_HI);
    end
  end

  always_comb begin
    next_pev_valid = 1'b0;
    next_ev_addr   = eventing_address;
    next_pev2_arm  = pev2_arm && !eee_done;
    if (pev2_arm && eee_done && pev_pending) begin
      next_pev_valid = 1'b1;
      next_ev_addr   = landing_addr;
    end else if (pev_pending) begin
      // Leaf records stay off inside an opt-out enclave
      if (ev_kind == ETP_EV_SLEAF && st != ETP_ST_OPTOUT) begin
        next_pev_valid = 1'b1;
        next_ev_addr   = ev_ip;
      end else if (is_entry && st == ETP_ST_OUT && ev_optin) begin
        next_pev_valid = 1'b1;
        next_ev_addr   = ev_ip;
      end else if (ev_kind == ETP_EV_EXIT && st != ETP_ST_OUT) begin
        next_pev_valid = 1'b1;
        next_ev_addr   = (st == ETP_ST_OPTIN) ? ev_ip : entry_ip;
      end else if (ev_kind == ETP_EV_AEX && st != ETP_ST_OUT) begin
        next_pev_valid = 1'b1;
        next_ev_addr   = (st == ETP_ST_OPTIN) ? ssa_ip : entry_ip;
      end
    end
    if (ev_kind == ETP_EV_AEX && st != ETP_ST_OUT) begin
      next_pev2_arm = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ss_exc                 <= 1'b0;
      anti_interference_flag <= 1'b0;
      perf_global_state      <= '0;
      gp_ctr_en              <= '1;
      fix_ctr_en             <= '1;
      pev_en                 <= 1'b1;
      sib_both_eff           <= '0;
      pev_valid              <= 1'b0;
      eventing_address       <= '0;
      pev2_arm               <= 1'b0;
    end else begin
      ss_exc                 <= next_ss;
      anti_interference_flag <= optout_next;
      perf_global_state      <= 64'(optout_next) << GSTAT_AI_BIT;
      gp_ctr_en              <= {NUM_GP_CTR{!optout_next}};
      fix_ctr_en             <= next_fix;
      pev_en                 <= !optout_next;
      sib_both_eff           <= sib_optout ? '0 : sib_both_cfg;
      pev_valid              <= next_pev_valid;
      eventing_address       <= next_ev_addr;
      pev2_arm               <= next_pev2_arm;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  ss_resume_a: assert property (@(posedge mclk) disable iff (reset)
    (ev_kind == ETP_EV_RESUME || ev_kind == ETP_EV_AEX) |=> !ss_exc)
    else $error("single-step on resume or async exit");
  ss_exit_a: assert property (@(posedge mclk) disable iff (reset)
    branch_single_step && ev_kind == ETP_EV_EXIT && st != ETP_ST_OUT |=> ss_exc)
    else $error("no single-step after exit");
  optout_norec_a: assert property (@(posedge mclk) disable iff (reset)
    st == ETP_ST_OUT && is_entry && !ev_optin |=> !rec_valid)
    else $error("record pushed at opt-out entry");
  optout_gate_a: assert property (@(posedge mclk) disable iff (reset)
    st == ETP_ST_OUT && is_entry && !ev_optin |=>
      anti_interference_flag && gp_ctr_en == '0 && !fix_ctr_en[0] && fix_ctr_en[CYC_FIX_HI])
    else $error("opt-out entry did not gate counters");
  exit_resume_a: assert property (@(posedge mclk) disable iff (reset)
    st != ETP_ST_OUT && is_leave |=> pev_en && !perf_global_state[GSTAT_AI_BIT])
    else $error("monitoring not resumed at exit");
  optin_clear_a: assert property (@(posedge mclk) disable iff (reset)
    st == ETP_ST_OPTIN |=> !anti_interference_flag)
    else $error("flag set during opt-in");
  optout_exit_rec_a: assert property (@(posedge mclk) disable iff (reset)
    st == ETP_ST_OPTOUT && rec_at_entry && ev_kind == ETP_EV_EXIT && !rec_filter[FILT_FAR_BIT]
      |=> rec_valid && rec_src[ADDR_W-2:0] == $past(entry_ip[ADDR_W-2:0]))
    else $error("opt-out exit record source wrong");
  aex_second_a: assert property (@(posedge mclk) disable iff (reset)
    st == ETP_ST_OPTOUT && rec_at_entry && ev_kind == ETP_EV_AEX && ev_cause_rec
      |=> ##1 rec_valid && rec_src == $past(landing_addr))
    else $error("causing record not sourced from landing address");
  optout_pev_a: assert property (@(posedge mclk) disable iff (reset)
    st == ETP_ST_OUT && is_entry && !ev_optin && !pev2_arm |=> !pev_valid)
    else $error("precise record at opt-out entry");
  optout_leaf_a: assert property (@(posedge mclk) disable iff (reset)
    st == ETP_ST_OPTOUT && ev_kind == ETP_EV_SLEAF && !pev2_arm |=> !pev_valid)
    else $error("precise record inside opt-out enclave");
endmodule : etp_gate

// ===== test/etp_core_model.sv
// Model of core event delivery: exiting-event completion after async exit
`timescale 1ns/10ps
module etp_core_model
  import etp_pkg::*;
(
  input  wire logic             mclk,            // Core clock
  input  wire logic             reset,           // Sync reset
  input  wire etp_pkg::etp_ev_t ev_kind,         // Retired event kind
  input  wire logic [3:0]       dly,             // Delivery latency, cycles
  output logic                  eee_done = 1'b0  // Delivery finished pulse
);
  logic [3:0] cnt;
  logic [3:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (ev_kind == ETP_EV_AEX) begin
      next_cnt = dly;
    end else if (cnt != 4'h0) begin
      next_cnt = cnt - 4'h1;
    end
  end

  always_ff @(posedge mclk) begin
    cnt <= reset ? 4'h0 : next_cnt;
  end

  // Falling edge, like the rest of the stimulus, so the sample is clean
  always @(negedge mclk) begin
    eee_done <= (cnt == 4'h1);
  end
endmodule : etp_core_model

// ===== test/test_etp_gate.sv
// Self-checking testbench for enclave trace and perfmon gating
`timescale 1ns/10ps
module test_etp_gate;
  import etp_pkg::*;
  logic              mclk = 1'b0;
  logic              reset = 1'b1;
  etp_ev_t           ev_kind = ETP_EV_NONE;
  logic              ev_optin = 1'b0;
  logic [63:0]       ev_ip = '0, ev_dst = '0, ssa_ip = '0;
  logic [63:0]       landing_addr = '0, cause_dst = '0, ipe;
  logic              bss = 1'b0, rec_enable = 1'b0, pev_pending = 1'b0;
  logic [FILT_W-1:0] rec_filter = '0;
  logic              ev_cause_rec = 1'b0, sib_optout = 1'b0, eee_done;
  logic [3:0]        sib_both_cfg = '0, dly = 4'h2, gp_ctr_en, sib_both_eff;
  logic              ss_exc, rec_valid, rec_ntx, ai_flag, pev_en, pev_valid;
  logic [63:0]       rec_src, rec_dst, pgs, ev_addr;
  logic [2:0]        fix_ctr_en;
  logic [15:0]       seed = 16'h7B70;
  int                fail_count = 0;
  int                num_checks = 0;

  always #2.5 mclk = ~mclk;

  etp_gate dut (.mclk(mclk), .reset(reset), .ev_kind(ev_kind), .ev_optin(ev_optin),
    .ev_ip(ev_ip), .ev_dst(ev_dst), .ssa_ip(ssa_ip), .landing_addr(landing_addr),
    .branch_single_step(bss), .rec_enable(rec_enable), .rec_filter(rec_filter),
    .pev_pending(pev_pending), .eee_done(eee_done), .ev_cause_rec(ev_cause_rec),
    .cause_dst(cause_dst), .sib_both_cfg(sib_both_cfg), .sib_optout(sib_optout),
    .ss_exc(ss_exc), .rec_valid(rec_valid), .rec_src(rec_src), .rec_dst(rec_dst),
    .rec_ntx(rec_ntx), .anti_interference_flag(ai_flag), .perf_global_state(pgs),
    .gp_ctr_en(gp_ctr_en), .fix_ctr_en(fix_ctr_en), .pev_en(pev_en),
    .sib_both_eff(sib_both_eff), .pev_valid(pev_valid), .eventing_address(ev_addr));

  etp_core_model core (.mclk(mclk), .reset(reset), .ev_kind(ev_kind), .dly(dly),
    .eee_done(eee_done));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [63:0] rnd();
    logic [63:0] v;
    v = '0;
    for (int i = 0; i < 4; i++) begin
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      v = {v[47:0], seed};
    end
    return v;
  endfunction : rnd

  // Far records carry the predicted mark in the top bit
  function automatic logic [63:0] far(input logic [63:0] a);
    return {1'b1, a[62:0]};
  endfunction : far

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic rc(input logic v, input logic [63:0] s, input logic [63:0] d);
    chk(rec_valid, v);
    if (v) begin
      chk(rec_src, s);
      chk(rec_dst, d);
    end
  endtask : rc

  // Called at a falling edge; leaves the event up for the caller to replace
  task automatic ev(input etp_ev_t k, input logic oi);
    ev_kind = k;
    ev_optin = oi;
    ev_ip = rnd();
    ev_dst = rnd();
    @(negedge mclk);
  endtask : ev

  task automatic idle();
    ev_kind = ETP_EV_NONE;
    @(negedge mclk);
  endtask : idle

  // Bounded wait for delivery end, then the landing-address record
  task automatic eee_wait();
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (eee_done !== 1'b1 && n < 20);
    chk(eee_done, 1'b1);
    chk(pev_valid, 1'b1);
    chk(ev_addr, landing_addr);
  endtask : eee_wait

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (3) @(negedge mclk);
    reset = 1'b0;
    chk(pgs, 64'h0);
    chk(gp_ctr_en, 4'hF);
    chk(fix_ctr_en, 3'h7);
    chk(pev_en, 1'b1);
    $display("test reset finished");
    bss = 1'b1;
    rec_enable = 1'b1;
    pev_pending = 1'b1;
    ev(ETP_EV_ENTER, 1'b1);
    chk(ss_exc, 1'b1);
    rc(1'b1, far(ev_ip), ev_dst);
    chk(rec_ntx, 1'b1);
    chk(pev_valid, 1'b1);
    chk(ev_addr, ev_ip);
    chk(ai_flag, 1'b0);
    for (int i = 0; i < 4; i++) begin
      ev(ETP_EV_BRANCH, 1'b1);
      rc(1'b1, ev_ip, ev_dst);
    end
    ev(ETP_EV_EXIT, 1'b1);
    chk(ss_exc, 1'b1);
    rc(1'b1, far(ev_ip), ev_dst);
    chk(ev_addr, ev_ip);
    ev(ETP_EV_RESUME, 1'b1);
    chk(ss_exc, 1'b0);
    rc(1'b1, far(ev_ip), ev_dst);
    ssa_ip = rnd();
    // Top bit set so the landing address reads the same with or without the mark
    landing_addr = rnd() | 64'h8000000000000000;
    ev(ETP_EV_AEX, 1'b1);
    chk(ss_exc, 1'b0);
    rc(1'b1, far(ssa_ip), landing_addr);
    chk(ev_addr, ssa_ip);
    idle();
    eee_wait();
    $display("test opt_in finished");
    sib_both_cfg = 4'(rnd());
    sib_optout = 1'b1;
    ev(ETP_EV_ENTER, 1'b0);
    ipe = ev_ip;
    rc(1'b0, '0, '0);
    chk(pev_valid, 1'b0);
    chk(pgs, 64'h1000000000000000);
    chk(ai_flag, 1'b1);
    chk(gp_ctr_en, 4'h0);
    chk(fix_ctr_en, 3'h6);
    chk(pev_en, 1'b0);
    chk(sib_both_eff, 4'h0);
    ev(ETP_EV_BRANCH, 1'b0);
    rc(1'b0, '0, '0);
    sib_optout = 1'b0;
    ev(ETP_EV_EXIT, 1'b0);
    chk(ss_exc, 1'b1);
    rc(1'b1, far(ipe), ev_dst);
    chk(ev_addr, ipe);
    chk(ai_flag, 1'b0);
    chk(gp_ctr_en, 4'hF);
    chk(pev_en, 1'b1);
    chk(sib_both_eff, sib_both_cfg);
    ev(ETP_EV_RESUME, 1'b0);
    ipe = ev_ip;
    chk(ss_exc, 1'b0);
    rc(1'b0, '0, '0);
    ev_cause_rec = 1'b1;
    cause_dst = rnd();
    dly = 4'h6;
    ev(ETP_EV_AEX, 1'b0);
    chk(ss_exc, 1'b0);
    rc(1'b1, far(ipe), landing_addr);
    chk(ev_addr, ipe);
    idle();
    rc(1'b1, landing_addr, cause_dst);
    ev_cause_rec = 1'b0;
    eee_wait();
    $display("test opt_out finished");
    bss = 1'b0;
    rec_filter = 16'h0100;
    ev(ETP_EV_ENTER, 1'b1);
    chk(ss_exc, 1'b0);
    rc(1'b0, '0, '0);
    ev(ETP_EV_BRANCH, 1'b1);
    rc(1'b1, ev_ip, ev_dst);
    ev(ETP_EV_EXIT, 1'b1);
    rc(1'b0, '0, '0);
    rec_filter = '0;
    rec_enable = 1'b0;
    ev(ETP_EV_ENTER, 1'b0);
    ev(ETP_EV_SLEAF, 1'b0);
    chk(pev_valid, 1'b0);
    ev(ETP_EV_EXIT, 1'b0);
    rc(1'b0, '0, '0);
    ev(ETP_EV_SLEAF, 1'b0);
    chk(pev_valid, 1'b1);
    chk(ev_addr, ev_ip);
    idle();
    $display("test filter_leaf finished");
    final_report();
  end

  // Whole run is a few dozen cycles; this limit only catches a hang
  initial begin
    #20000;
    fail_count++;
    final_report();
  end
endmodule : test_etp_gate
